// [src/bbiows_top.sv]
`timescale 1ns/100ps
module bbiows_top
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Secondary side events, one-cycle pulses
	input wire logic sec_parity_err_i,
	input wire logic sec_cpl_abort_sent_i,
	input wire logic sec_rcv_cpl_abort_i,
	input wire logic sec_rcv_unsup_req_i,
	input wire logic err_msg_sent_i,
	input wire logic sec_poisoned_i,
	// I/O decode
	input wire logic io_req_i,
	input wire logic [31:0] io_addr_i,
	output logic io_fwd_o,
	output logic [7:0] sec_bus_o,
	output logic [7:0] sub_bus_o
);

////////////////////////////////////////////////////////////////////////////////

typedef struct packed
{
	logic [31:0] dat;
	logic ack;
	logic fwd;
	logic [7:0] pri;
	logic [7:0] sec;
	logic [7:0] sub;
	logic [3:0] base;
	logic [3:0] limit;
	logic [5:0] sts;
	logic perr_en;
	logic serr_en;
	logic [15:0] base_up;
	logic [15:0] limit_up;
} bbiows_state_t;

bbiows_state_t state_r;
bbiows_state_t state_nxt;

logic acc;
logic wr;
logic [31:0] rd_bus;
logic [31:0] rd_io;
logic [31:0] rd_ctl;
logic [31:0] bot;
logic [31:0] top;
logic [5:0] ev;
logic [5:0] clr;

////////////////////////////////////////////////////////////////////////////////

always_comb
begin
	// Fresh request only; ack drops the cycle after it is given
	acc = cyc_i & stb_i & ~state_r.ack;
	wr = acc & we_i;
	rd_bus = {8'h00, state_r.sub, state_r.sec, state_r.pri};
	// Parity flag sits alone at bit 24, below the hardwired 26:25 pair
	rd_io = {state_r.sts[5:1], 2'b00, state_r.sts[0],
		1'b0, 1'b0, 1'b0, 5'h00,
		state_r.limit, bbiows_pkg::IO_32BIT_CAP,
		state_r.base, bbiows_pkg::IO_32BIT_CAP};
	rd_ctl = {state_r.base_up, 14'h0000, state_r.serr_en,
		state_r.perr_en};
	// Window bounds
	bot = {state_r.base_up, state_r.base, bbiows_pkg::IO_LOW_ZERO};
	top = {state_r.limit_up, state_r.limit, bbiows_pkg::IO_LOW_ONES};
	// Event order matches sts bits 5..0, read back as status bits {31,30,29,28,27,24}
	ev = {sec_poisoned_i,
		err_msg_sent_i & state_r.serr_en,
		sec_rcv_unsup_req_i,
		sec_rcv_cpl_abort_i,
		sec_cpl_abort_sent_i,
		sec_parity_err_i & state_r.perr_en};
	clr = 6'h00;
	if (wr && adr_i == bbiows_pkg::IO_STAT_OFS && sel_i[3])
	begin
		clr = {dat_i[bbiows_pkg::ST_POIS], dat_i[bbiows_pkg::ST_SERR],
			dat_i[bbiows_pkg::ST_RCV_UR], dat_i[bbiows_pkg::ST_RCV_CA],
			dat_i[bbiows_pkg::ST_SIG_CA], dat_i[bbiows_pkg::ST_PAR]};
	end
	state_nxt = state_r;
	state_nxt.ack = acc;
	state_nxt.dat = 32'h00000000;
	// Set beats clear in the same cycle
	state_nxt.sts = (state_r.sts & ~clr) | ev;
	state_nxt.fwd = io_req_i && io_addr_i >= bot && io_addr_i <= top;
	if (acc && !we_i)
	begin
		case (adr_i)
			bbiows_pkg::BUS_NUM_OFS: state_nxt.dat = rd_bus;
			bbiows_pkg::IO_STAT_OFS: state_nxt.dat = rd_io;
			bbiows_pkg::CTRL_OFS: state_nxt.dat = rd_ctl;
			default: state_nxt.dat = 32'h00000000;
		endcase
	end
	if (wr && adr_i == bbiows_pkg::BUS_NUM_OFS)
	begin
		if (sel_i[0])
			state_nxt.pri = dat_i[bbiows_pkg::PRI_LSB +: 8];
		if (sel_i[1])
			state_nxt.sec = dat_i[bbiows_pkg::SEC_LSB +: 8];
		if (sel_i[2])
			state_nxt.sub = dat_i[bbiows_pkg::SUB_LSB +: 8];
	end
	if (wr && adr_i == bbiows_pkg::IO_STAT_OFS)
	begin
		if (sel_i[0])
			state_nxt.base = dat_i[bbiows_pkg::BASE_LSB +: 4];
		if (sel_i[1])
			state_nxt.limit = dat_i[bbiows_pkg::LIMIT_LSB +: 4];
	end
	if (wr && adr_i == bbiows_pkg::CTRL_OFS)
	begin
		if (sel_i[0])
		begin
			state_nxt.perr_en = dat_i[bbiows_pkg::CTL_PERR_EN];
			state_nxt.serr_en = dat_i[bbiows_pkg::CTL_SERR_EN];
		end
		// Stand-ins for the separate upper-half registers
		if (sel_i[3] && sel_i[2])
			state_nxt.base_up = dat_i[bbiows_pkg::CTL_UP_LSB +: 16];
		if (sel_i[1] && sel_i[2] && !sel_i[3])
			state_nxt.limit_up = dat_i[bbiows_pkg::CTL_UP_LSB +: 16];
	end
	if (rst_i)
	begin
		state_nxt = '0;
		state_nxt.pri = bbiows_pkg::BUS_RST;
		state_nxt.sec = bbiows_pkg::BUS_RST;
		state_nxt.sub = bbiows_pkg::BUS_RST;
		state_nxt.base = bbiows_pkg::IO_NIB_RST;
		state_nxt.limit = bbiows_pkg::IO_NIB_RST;
	end
end

always_ff @(posedge clk_i)
begin
	state_r <= state_nxt;
end

////////////////////////////////////////////////////////////////////////////////

assign dat_o = state_r.dat;
assign ack_o = state_r.ack;
assign io_fwd_o = state_r.fwd;
assign sec_bus_o = state_r.sec;
assign sub_bus_o = state_r.sub;

endmodule

// [src/bbiows_pkg.sv]
// Function
// - Primary bus number, 8-bit read-write in bits 7:0, resets to zero.
// - Secondary bus number, 8-bit read-write in bits 15:8, resets to zero.
// - Subordinate bus number, 8-bit read-write in bits 23:16, resets zero.
// - Secondary latency timer byte 31:24 is read-only zero.
// - Low nibbles of I/O base and limit bytes read one, 32-bit I/O.
// - Base bits 7:4 give window bottom address 15:12; low 12 bits zero.
// - Limit bits 15:12 give window top address 15:12; low bits all ones.
// - Forward I/O inside base-to-limit window; upper halves elsewhere.
// - Bit 24 sets on secondary parity error, never while parity response off.
// - Bit 27 sets when completing secondary request with completer abort.
// - Bit 28 sets on received completion with completer-abort status.
// - Bit 29 sets on received completion with unsupported-request status.
// - Bit 30 sets on sent fatal or nonfatal message, SERR enabled.
// - Bit 31 sets whenever the secondary side receives a poisoned TLP.
// - Status bits 21, 23 and 26:25 read-only zero.
package bbiows_pkg;
	localparam logic [7:0] BUS_NUM_OFS = 8'h18;
	localparam logic [7:0] IO_STAT_OFS = 8'h1C;
	localparam logic [7:0] CTRL_OFS = 8'h40;
	localparam logic [7:0] BUS_RST = 8'h00;
	localparam logic [3:0] IO_NIB_RST = 4'h0;
	localparam logic [3:0] IO_32BIT_CAP = 4'h1;
	localparam logic [11:0] IO_LOW_ONES = 12'hFFF;
	localparam logic [11:0] IO_LOW_ZERO = 12'h000;
	localparam int PRI_LSB = 0;
	localparam int SEC_LSB = 8;
	localparam int SUB_LSB = 16;
	localparam int BASE_LSB = 4;
	localparam int LIMIT_LSB = 12;
	localparam int ST_PAR = 24;
	localparam int ST_SIG_CA = 27;
	localparam int ST_RCV_CA = 28;
	localparam int ST_RCV_UR = 29;
	localparam int ST_SERR = 30;
	localparam int ST_POIS = 31;
	localparam int CTL_PERR_EN = 0;
	localparam int CTL_SERR_EN = 1;
	localparam int CTL_UP_LSB = 16;
endpackage

// [sim/bbiows_props.sv]
`timescale 1ns/100ps
module bbiows_props
(
	// Watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic io_req_i,
	input wire logic io_fwd_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence rd1c_s;
		ack_o && !we_i && adr_i == 8'h1C;
	endsequence
	ack_resp_a: assert property (req_s |=> ack_o)
		else $error("no ack");
	ack_once_a: assert property (ack_o |=> !ack_o)
		else $error("long ack");
	lat_zero_a: assert property (ack_o && adr_i == 8'h18 |->
		dat_o[31:24] == 8'h00) else $error("timer not zero");
	io_cap_a: assert property (rd1c_s |->
		dat_o[3:0] == 4'h1 && dat_o[11:8] == 4'h1) else $error("io cap");
	rsvd_zero_a: assert property (rd1c_s |->
		dat_o[23:16] == 8'h00 && dat_o[26:25] == 2'h0) else $error("rsvd");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("data outside ack");
	fwd_idle_a: assert property (!io_req_i |=> !io_fwd_o)
		else $error("fwd without req");
	fwd_cause_a: assert property (io_fwd_o |-> $past(io_req_i))
		else $error("fwd cause");
endmodule
bind bbiows_top bbiows_props u_props (.*);

// [sim/bbiows_sec_model.sv]
`timescale 1ns/100ps
module bbiows_sec_model
(
	// Clock and command
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [2:0] ev_i,
	// Event pulses
	output logic [5:0] ev_o
);
	// Far side never holds an event
	always_ff @(posedge clk_i)
		ev_o <= go_i ? 6'h01 << ev_i : 6'h00;
endmodule

// [sim/bridge_bus_io_window_status_bench.sv]
`timescale 1ns/100ps
module bridge_bus_io_window_status_bench;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0;
	logic we_i = 1'h0, io_req_i = 1'h0, go = 1'h0, ack_o, io_fwd_o;
	logic [7:0] adr_i = 8'h00, sec_bus_o, sub_bus_o;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, io_addr_i = 32'h0, dat_o, rd, d;
	logic [2:0] ev = 3'h0;
	logic [5:0] ev_o;
	int error_cnt = 0, n_checks = 0, seed = 32'h38DBFA47;
	initial forever #10 clk_i = ~clk_i;
	bbiows_top dut (.*, .sec_parity_err_i(ev_o[0]),
		.sec_cpl_abort_sent_i(ev_o[1]), .sec_rcv_cpl_abort_i(ev_o[2]),
		.sec_rcv_unsup_req_i(ev_o[3]), .err_msg_sent_i(ev_o[4]),
		.sec_poisoned_i(ev_o[5]));
	bbiows_sec_model sec (.clk_i, .go_i(go), .ev_i(ev), .ev_o);
	function logic [31:0] io_exp(logic [31:0] v, logic [7:0] st);
		return {st, 8'h00, v[15:12], 4'h1, v[7:4], 4'h1};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] v);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, s, v};
		do @(posedge clk_i); while (ack_o !== 1'h1);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'h0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, 4'hF, 32'h0);
		chk(rd, e);
	endtask
	task io(input logic [31:0] a, input logic e);
		@(posedge clk_i);
		{io_req_i, io_addr_i} <= {1'h1, a};
		repeat (2) @(posedge clk_i);
		chk({31'h0, io_fwd_o}, {31'h0, e});
		io_req_i <= 1'h0;
	endtask
	task ev_pulse(input int k);
		@(posedge clk_i);
		{go, ev} <= {1'h1, 3'(k)};
		@(posedge clk_i);
		go <= 1'h0;
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		rdc(8'h18, 32'h0);
		rdc(8'h1C, 32'h0101);
		io(32'h0FFF, 1'h1);
		io(32'h1000, 1'h0);
		$display("reset test done");
		repeat (4)
		begin
			d = $random(seed);
			wb(1'h1, 8'h18, 4'hF, d);
			rdc(8'h18, {8'h00, d[23:0]});
			chk({16'h0, sec_bus_o, sub_bus_o}, {16'h0, d[15:8], d[23:16]});
			d[15:12] = d[15:12] | d[7:4];
			wb(1'h1, 8'h1C, 4'h3, d);
			rdc(8'h1C, io_exp(d, 8'h00));
			io({16'h0, d[7:4], 12'h000}, 1'h1);
			io({16'h0, d[7:4], 12'h000} - 32'h1, 1'h0);
			io({16'h0, d[15:12], 12'hFFF}, 1'h1);
			io({16'h0, d[15:12], 12'hFFF} + 32'h1, 1'h0);
		end
		$display("window test done");
		for (int k = 0; k < 6; k++) ev_pulse(k);
		rdc(8'h1C, io_exp(d, 8'hB8));
		wb(1'h1, 8'h1C, 4'h8, 32'hFF000000);
		rdc(8'h1C, io_exp(d, 8'h00));
		wb(1'h1, 8'h40, 4'h1, 32'h3);
		ev_pulse(0);
		ev_pulse(4);
		wb(1'h1, 8'h1C, 4'h8, 32'h0);
		rdc(8'h1C, io_exp(d, 8'h41));
		rdc(8'h30, 32'h0);
		$display("status test done");
		final_report;
	end
	initial
	begin
		repeat (3000) @(posedge clk_i);
		error_cnt++;
		final_report;
	end
endmodule
